// file: intc_pkg.sv
package intc_pkg;

    localparam int NUM_SRC = 10;
    localparam int SRC_W = 4;
    localparam int LVL_W = 2;
    localparam int NUM_LVL = 4;
    localparam int VEC_W = 16;
    localparam int REG_W = 8;
    localparam int BIT_W = 3;

    // one machine cycle is six cpu clocks
    localparam int MC_CLOCKS = 6;
    localparam logic [2:0] MC_LAST = 3'(MC_CLOCKS - 1);
    localparam logic [2:0] MC_RESET = 3'h0;

    localparam int GLOBAL_EN_BIT = 7;

    // sources in arbitration rank order, index 0 ranks highest
    typedef enum logic [SRC_W-1:0] {
        SRC_EXT0,
        SRC_BROWNOUT,
        SRC_WATCHDOG,
        SRC_TIMER0,
        SRC_TWOWIRE,
        SRC_KEYPAD,
        SRC_COMP1,
        SRC_TIMER1,
        SRC_SERIAL,
        SRC_BUS_TIMEOUT
    } src_id_t;

    // set where the source's enable and priority bits live in bank b
    localparam logic [NUM_SRC-1:0] SRC_IN_B = 10'h270;
    localparam logic [NUM_SRC-1:0][BIT_W-1:0] SRC_BIT = {
        3'h7, 3'h4, 3'h3, 3'h5, 3'h1, 3'h0, 3'h1, 3'h6, 3'h5, 3'h0
    };
    localparam logic [NUM_SRC-1:0][VEC_W-1:0] SRC_VECTOR = {
        16'h0073, 16'h0023, 16'h001B, 16'h0063, 16'h003B,
        16'h0033, 16'h000B, 16'h0053, 16'h002B, 16'h0003
    };
    // sources allowed to end power down
    localparam logic [NUM_SRC-1:0] WAKE_CAPABLE = 10'h067;

    localparam logic [VEC_W-1:0] VECTOR_RESET = 16'h0000;
    localparam logic [NUM_LVL-1:0] IN_SERVICE_RESET = 4'h0;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic SAMPLE_RESET = 1'b1;

    typedef struct packed {
        logic timer0OverflowFlag;
        logic timer1OverflowFlag;
        logic serialTxFlag;
        logic serialRxFlag;
        logic brownoutFlag;
        logic twowireAttentionFlag;
        logic keypadFlag;
        logic watchdogOverflowFlag;
        logic comparator1Flag;
        logic busTimeoutFlag;
    } src_flags_t;

    typedef struct packed {
        logic request;
        logic [VEC_W-1:0] vector;
        logic [SRC_W-1:0] source;
        logic [LVL_W-1:0] level;
    } cpu_resp_t;

endpackage

// file: ext_int_detect.sv
`timescale 1ns/1ps
module ext_int_detect
    import intc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic extIntPin,
    input wire logic sampleTick,
    input wire logic extIntEdgeSelect,
    input wire logic hwClear,
    output logic extIntRequestFlag
);

    logic pinMeta;
    logic pinSync;
    logic samplePrev;
    logic next_samplePrev;
    logic next_flag;
    logic fallSeen;

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pinMeta <= SAMPLE_RESET;
            pinSync <= SAMPLE_RESET;
        end
        else
        begin
            pinMeta <= extIntPin;
            pinSync <= pinMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sampling and flag

    assign fallSeen = sampleTick && samplePrev && !pinSync;

    always_comb
    begin
        next_samplePrev = samplePrev;
        next_flag = extIntRequestFlag;
        if (sampleTick)
            next_samplePrev = pinSync;
        if (!extIntEdgeSelect)
        begin
            if (sampleTick)
                next_flag = !pinSync;
        end
        else
        begin
            if (hwClear)
                next_flag = 1'b0;
            if (fallSeen)
                next_flag = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            samplePrev <= SAMPLE_RESET;
            extIntRequestFlag <= FLAG_RESET;
        end
        else
        begin
            samplePrev <= next_samplePrev;
            extIntRequestFlag <= next_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence edgeFall;
        sampleTick && extIntEdgeSelect && samplePrev && !pinSync;
    endsequence

    sequence edgeAck;
        hwClear && extIntEdgeSelect && !fallSeen;
    endsequence

    AST_EDGE_SET: assert property (edgeFall |=> extIntRequestFlag)
        else $error("edge flag not set on falling sample");
    AST_EDGE_CLEAR: assert property (edgeAck |=> !extIntRequestFlag)
        else $error("edge flag not cleared on vectoring");
    AST_LEVEL_TRACK: assert property (
        sampleTick && !extIntEdgeSelect
        |=> extIntRequestFlag == !$past(pinSync))
        else $error("level flag does not track sample");
    AST_SAMPLE_ONLY: assert property (
        !sampleTick && !hwClear |=> $stable(extIntRequestFlag))
        else $error("flag changed between samples");

endmodule

// file: prio_arbiter.sv
`timescale 1ns/1ps
module prio_arbiter
    import intc_pkg::*;
#(
    parameter int N = NUM_SRC
)
(
    input wire logic [N-1:0] req,
    input wire logic [N-1:0][LVL_W-1:0] levels,
    output logic winValid,
    output logic [SRC_W-1:0] winner,
    output logic [LVL_W-1:0] winLevel
);

    logic [N-1:0] higherSeen;
    logic [N-1:0] earlierSeen;

    always_comb
    begin
        winValid = 1'b0;
        winner = '0;
        winLevel = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req[i] && (!winValid || levels[i] >= winLevel))
            begin
                winValid = 1'b1;
                winner = SRC_W'(i);
                winLevel = levels[i];
            end
        end
    end

    // helpers for the checks below
    for (genvar g = 0; g < N; g++)
    begin : gBeat
        assign higherSeen[g] = req[g] && levels[g] > winLevel;
        assign earlierSeen[g] = req[g] && levels[g] == winLevel
            && SRC_W'(g) < winner;
    end

    always_comb
    begin
        AST_LEVEL_FIRST: assert final (!winValid || higherSeen == '0)
            else $error("lower level chosen over higher");
        AST_RANK_TIE: assert final (!winValid || earlierSeen == '0)
            else $error("tie not broken by rank");
    end

endmodule

// file: prioritized_interrupt_controller.sv
`timescale 1ns/1ps
module prioritized_interrupt_controller
    import intc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic extIntPin,
    input wire logic extIntEdgeSelect,
    input wire logic [REG_W-1:0] intEnableRegA,
    input wire logic [REG_W-1:0] intEnableRegB,
    input wire logic [REG_W-1:0] intPrioLowA,
    input wire logic [REG_W-1:0] intPrioHighA,
    input wire logic [REG_W-1:0] intPrioLowB,
    input wire logic [REG_W-1:0] intPrioHighB,
    input wire src_flags_t srcFlags,
    input wire logic vectorTaken,
    input wire logic serviceDone,
    output cpu_resp_t cpuResp,
    output logic extIntRequestFlag,
    output logic [NUM_LVL-1:0] inService,
    output logic wakeFromIdle,
    output logic wakeFromPowerDown
);

    logic [2:0] mcPhase;
    logic [2:0] next_mcPhase;
    logic sampleTick;
    logic globalIntEnable;
    logic [NUM_SRC-1:0] rawReq;
    logic [NUM_SRC-1:0] enabled;
    logic [NUM_SRC-1:0] req;
    logic [NUM_SRC-1:0][LVL_W-1:0] levels;
    logic winValid;
    logic [SRC_W-1:0] winner;
    logic [LVL_W-1:0] winLevel;
    logic [LVL_W-1:0] topLevel;
    logic anyInService;
    logic preemptOk;
    logic hwClear;
    logic [NUM_LVL-1:0] next_inService;
    cpu_resp_t next_cpuResp;
    logic next_wakeFromIdle;
    logic next_wakeFromPowerDown;

    ////////////////////////////////////////////////////////////////////////
    // machine cycle timing

    always_comb
    begin
        if (mcPhase == MC_LAST)
            next_mcPhase = MC_RESET;
        else
            next_mcPhase = mcPhase + 3'h1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            mcPhase <= MC_RESET;
        else
            mcPhase <= next_mcPhase;
    end

    assign sampleTick = mcPhase == MC_LAST;

    ////////////////////////////////////////////////////////////////////////
    // external interrupt pin

    // only a taken external vector clears
    assign hwClear = vectorTaken && cpuResp.source == SRC_EXT0;

    ext_int_detect uExtInt (
        .clk(clk),
        .rst(rst),
        .extIntPin(extIntPin),
        .sampleTick(sampleTick),
        .extIntEdgeSelect(extIntEdgeSelect),
        .hwClear(hwClear),
        .extIntRequestFlag(extIntRequestFlag)
    );

    ////////////////////////////////////////////////////////////////////////
    // request sources

    always_comb
    begin
        rawReq = '0;
        rawReq[SRC_EXT0] = extIntRequestFlag;
        rawReq[SRC_BROWNOUT] = srcFlags.brownoutFlag;
        rawReq[SRC_WATCHDOG] = srcFlags.watchdogOverflowFlag;
        rawReq[SRC_TIMER0] = srcFlags.timer0OverflowFlag;
        rawReq[SRC_TWOWIRE] = srcFlags.twowireAttentionFlag;
        rawReq[SRC_KEYPAD] = srcFlags.keypadFlag;
        rawReq[SRC_COMP1] = srcFlags.comparator1Flag;
        rawReq[SRC_TIMER1] = srcFlags.timer1OverflowFlag;
        rawReq[SRC_SERIAL] = srcFlags.serialTxFlag
            || srcFlags.serialRxFlag;
        rawReq[SRC_BUS_TIMEOUT] = srcFlags.busTimeoutFlag;
    end

    for (genvar g = 0; g < NUM_SRC; g++)
    begin : gSrc
        // enable from bank a or b
        assign enabled[g] = SRC_IN_B[g] ? intEnableRegB[SRC_BIT[g]]
            : intEnableRegA[SRC_BIT[g]];
        // each source picks its own level
        assign levels[g] = SRC_IN_B[g]
            ? {intPrioHighB[SRC_BIT[g]], intPrioLowB[SRC_BIT[g]]}
            : {intPrioHighA[SRC_BIT[g]], intPrioLowA[SRC_BIT[g]]};
    end

    assign globalIntEnable = intEnableRegA[GLOBAL_EN_BIT];

    assign req = rawReq & enabled & {NUM_SRC{globalIntEnable}};

    ////////////////////////////////////////////////////////////////////////
    // arbitration

    prio_arbiter #(
        .N(NUM_SRC)
    ) uArb (
        .req(req),
        .levels(levels),
        .winValid(winValid),
        .winner(winner),
        .winLevel(winLevel)
    );

    // highest level now being serviced
    always_comb
    begin
        topLevel = '0;
        for (int i = 0; i < NUM_LVL; i++)
        begin
            if (inService[i])
                topLevel = LVL_W'(i);
        end
    end

    assign anyInService = inService != '0;

    assign preemptOk = !anyInService || winLevel > topLevel;

    ////////////////////////////////////////////////////////////////////////
    // in-service levels

    always_comb
    begin
        next_inService = inService;
        // returning ends the innermost service
        if (serviceDone)
            next_inService[topLevel] = 1'b0;
        if (vectorTaken)
            next_inService[cpuResp.level] = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            inService <= IN_SERVICE_RESET;
        else
            inService <= next_inService;
    end

    ////////////////////////////////////////////////////////////////////////
    // request to the cpu

    always_comb
    begin
        next_cpuResp = cpuResp;
        next_cpuResp.request = 1'b0;
        if (sampleTick && winValid)
        begin
            next_cpuResp.request = preemptOk;
            next_cpuResp.vector = SRC_VECTOR[winner];
            next_cpuResp.source = winner;
            next_cpuResp.level = winLevel;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cpuResp.request <= 1'b0;
            cpuResp.vector <= VECTOR_RESET;
            cpuResp.source <= SRC_EXT0;
            cpuResp.level <= '0;
        end
        else
            cpuResp <= next_cpuResp;
    end

    ////////////////////////////////////////////////////////////////////////
    // wakeup

    always_comb
    begin
        next_wakeFromIdle = |(rawReq & enabled);
        next_wakeFromPowerDown = |(rawReq & enabled & WAKE_CAPABLE);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wakeFromIdle <= 1'b0;
            wakeFromPowerDown <= 1'b0;
        end
        else
        begin
            wakeFromIdle <= next_wakeFromIdle;
            wakeFromPowerDown <= next_wakeFromPowerDown;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence tickBlocked;
        sampleTick && anyInService && winLevel <= topLevel;
    endsequence

    sequence tickIdle;
        sampleTick && req == '0;
    endsequence

    sequence extTaken;
        vectorTaken && cpuResp.source == SRC_EXT0 && extIntEdgeSelect;
    endsequence

    AST_STROBE_TICK: assert property (
        cpuResp.request |-> $past(mcPhase) == MC_LAST
        ##1 !cpuResp.request [*5])
        else $error("request strobe off the machine cycle");
    AST_GLOBAL_OFF: assert property (
        sampleTick && !globalIntEnable |=> !cpuResp.request)
        else $error("request while globally disabled");
    AST_NO_ENABLED: assert property (tickIdle |=> !cpuResp.request)
        else $error("request with no enabled source");
    AST_NO_PREEMPT: assert property (tickBlocked |=> !cpuResp.request)
        else $error("preempted by equal or lower level");
    AST_VECTOR_MAP: assert property (
        cpuResp.request |-> cpuResp.vector == SRC_VECTOR[cpuResp.source])
        else $error("vector does not match source");
    AST_WIN_LEVEL: assert property (
        sampleTick && winValid |=> cpuResp.level == $past(levels[winner]))
        else $error("presented level is not the source level");
    AST_PD_WAKE: assert property (
        wakeFromPowerDown |-> $past(|(rawReq & enabled & WAKE_CAPABLE)))
        else $error("power down wake from a non-wake source");
    AST_EXT_WAKE: assert property (
        extIntRequestFlag && intEnableRegA[SRC_BIT[SRC_EXT0]]
        |=> wakeFromIdle && wakeFromPowerDown)
        else $error("enabled external request did not wake");
    AST_SERVICE_MARK: assert property (
        vectorTaken |=> inService[$past(cpuResp.level)])
        else $error("taken level not marked in service");
    AST_EXT_CLEAR: assert property (
        extTaken and !sampleTick |=> !extIntRequestFlag)
        else $error("edge flag kept after vectoring");
    AST_SERVICE_END: assert property (
        serviceDone && !vectorTaken && anyInService
        |=> !inService[$past(topLevel)])
        else $error("return left the innermost level set");

endmodule

// file: cpu_core_model.sv
`timescale 1ns/1ps
module cpu_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic strobe,
    input wire logic takeEn,
    input wire logic slowTake,
    input wire logic doneReq,
    output logic vectorTaken,
    output logic serviceDone
);
    logic [2:0] pend;

    // a slow take lands three cycles late, still ahead of the next tick
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pend <= 3'h0;
            vectorTaken <= 1'b0;
            serviceDone <= 1'b0;
        end
        else
        begin
            pend <= {pend[1:0], strobe && takeEn && slowTake};
            vectorTaken <= (strobe && takeEn && !slowTake) || pend[2];
            serviceDone <= doneReq;
        end
    end
endmodule

// file: test_prioritized_interrupt_controller.sv
`timescale 1ns/1ps
`define CHECK(nm, ex, got) \
    samplesChecked++; \
    if ((got) !== (ex)) \
    begin \
        $display("BAD %s exp %0h got %0h", nm, ex, got); \
        badCount++; \
    end
module test_prioritized_interrupt_controller
    import intc_pkg::*;
;
    localparam logic [9:0] IN_B = 10'h270;
    localparam logic [9:0] WAKES = 10'h067;
    localparam logic [2:0] POS [10] = '{3'h0, 3'h5, 3'h6, 3'h1, 3'h0,
        3'h1, 3'h5, 3'h3, 3'h4, 3'h7};
    localparam logic [15:0] VEC [10] = '{16'h0003, 16'h002B, 16'h0053,
        16'h000B, 16'h0033, 16'h003B, 16'h0063, 16'h001B, 16'h0023, 16'h0073};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic extIntPin = 1'b1;
    logic extIntEdgeSelect = 1'b0;
    logic [7:0] enA = 8'h00, enB = 8'h00;
    logic [7:0] loA = 8'h00, hiA = 8'h00, loB = 8'h00, hiB = 8'h00;
    src_flags_t srcFlags = '0;
    logic takeEn = 1'b0, slowTake = 1'b0, doneReq = 1'b0;
    logic vectorTaken, serviceDone, extIntRequestFlag;
    logic wakeFromIdle, wakeFromPowerDown;
    logic [3:0] inService;
    cpu_resp_t cpuResp;
    logic [9:0] req = '0, en = '0;
    logic [9:0][1:0] lvl = '0;
    logic gEn = 1'b0, edgeMode = 1'b0, take = 1'b0, slow = 1'b0;
    logic rxPath = 1'b0;
    int badCount = 0, samplesChecked = 0;

    always #12.5 clk = ~clk;

    prioritized_interrupt_controller dut (.clk(clk), .rst(rst),
        .extIntPin(extIntPin), .extIntEdgeSelect(extIntEdgeSelect),
        .intEnableRegA(enA), .intEnableRegB(enB), .intPrioLowA(loA),
        .intPrioHighA(hiA), .intPrioLowB(loB), .intPrioHighB(hiB),
        .srcFlags(srcFlags), .vectorTaken(vectorTaken),
        .serviceDone(serviceDone), .cpuResp(cpuResp),
        .extIntRequestFlag(extIntRequestFlag), .inService(inService),
        .wakeFromIdle(wakeFromIdle), .wakeFromPowerDown(wakeFromPowerDown));

    cpu_core_model cpu (.clk(clk), .rst(rst), .strobe(cpuResp.request),
        .takeEn(takeEn), .slowTake(slowTake), .doneReq(doneReq),
        .vectorTaken(vectorTaken), .serviceDone(serviceDone));

    ///////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // maps per-source settings onto the register bit positions
    task automatic apply();
        logic [7:0] ea = {gEn, 7'h00};
        logic [7:0] eb = 8'h00, la = 8'h00, lb = 8'h00;
        logic [7:0] ha = 8'h00, hb = 8'h00;
        for (int i = 0; i < 10; i++)
        begin
            if (IN_B[i])
            begin
                eb[POS[i]] = en[i];
                lb[POS[i]] = lvl[i][0];
                hb[POS[i]] = lvl[i][1];
            end
            else
            begin
                ea[POS[i]] = en[i];
                la[POS[i]] = lvl[i][0];
                ha[POS[i]] = lvl[i][1];
            end
        end
        @(posedge clk);
        enA <= ea;
        enB <= eb;
        loA <= la;
        loB <= lb;
        hiA <= ha;
        hiB <= hb;
        takeEn <= take;
        slowTake <= slow;
        extIntEdgeSelect <= edgeMode;
        extIntPin <= !req[0];
        srcFlags <= {req[3], req[7], req[8] && !rxPath, req[8] && rxPath,
            req[1], req[4], req[5], req[2], req[6], req[9]};
    endtask

    task automatic quiet();
        req = '0;
        apply();
        cyc(14);
    endtask

    task automatic waitStrobe(input logic [3:0] src, input logic [1:0] lv);
        int n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (cpuResp.request !== 1'b1 && n < 30);
        `CHECK("strobe", 1'b1, cpuResp.request)
        `CHECK("source", src, cpuResp.source)
        `CHECK("vector", VEC[src], cpuResp.vector)
        `CHECK("level", lv, cpuResp.level)
        if (n >= 30)
            conclude();
    endtask

    task automatic noStrobe();
        int hits = 0;
        repeat (14)
        begin
            @(negedge clk);
            if (cpuResp.request !== 1'b0)
                hits++;
        end
        `CHECK("no strobe", 0, hits)
    endtask

    task automatic finishService();
        @(posedge clk);
        doneReq <= 1'b1;
        @(posedge clk);
        doneReq <= 1'b0;
        cyc(3);
    endtask

    ///////////////////////////////////////////////////////////////////////////
    task automatic vectorScan();
        gEn = 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            quiet();
            en = 10'h001 << i;
            req = 10'h001 << i;
            apply();
            waitStrobe(4'(i), 2'h0);
            `CHECK("idle wake", 1'b1, wakeFromIdle)
            `CHECK("pd wake", WAKES[i], wakeFromPowerDown)
        end
    endtask

    task automatic blockCheck();
        quiet();
        en = 10'h3FF;
        req = 10'h3FF;
        gEn = 1'b0;
        apply();
        noStrobe();
        en = 10'h000;
        gEn = 1'b1;
        apply();
        noStrobe();
        `CHECK("wake off", 1'b0, wakeFromIdle)
    endtask

    task automatic rankScan();
        en = 10'h3FF;
        lvl = {10{2'h1}};
        // serial requests now arrive on the receive flag
        rxPath = 1'b1;
        for (int k = 0; k < 10; k++)
        begin
            quiet();
            // pin path is slower, so it is given a head start
            req = (10'h3FF << k) & 10'h001;
            apply();
            cyc(14);
            req = 10'h3FF << k;
            apply();
            waitStrobe(4'(k), 2'h1);
        end
    endtask

    task automatic levelPick();
        quiet();
        lvl = '0;
        lvl[9] = 2'h2;
        lvl[1] = 2'h1;
        req = 10'h20A;
        apply();
        waitStrobe(4'h9, 2'h2);
        lvl[3] = 2'h3;
        apply();
        cyc(7);
        waitStrobe(4'h3, 2'h3);
    endtask

    task automatic preempt();
        quiet();
        lvl = '0;
        lvl[7] = 2'h1;
        req = 10'h080;
        take = 1'b1;
        apply();
        waitStrobe(4'h7, 2'h1);
        cyc(3);
        `CHECK("in service", 4'h2, inService)
        lvl[3] = 2'h1;
        req = 10'h088;
        apply();
        noStrobe();
        lvl[3] = 2'h3;
        slow = 1'b1;
        apply();
        waitStrobe(4'h3, 2'h3);
        cyc(6);
        `CHECK("nested", 4'hA, inService)
        lvl[2] = 2'h3;
        req = 10'h08C;
        take = 1'b0;
        slow = 1'b0;
        apply();
        noStrobe();
        req = 10'h080;
        apply();
        finishService();
        `CHECK("unwind", 4'h2, inService)
        finishService();
        `CHECK("idle", 4'h0, inService)
    endtask

    task automatic levelPin();
        quiet();
        en = 10'h001;
        lvl = '0;
        take = 1'b1;
        // pin held low until the request is generated a second time, after the first service ends
        req = 10'h001;
        apply();
        waitStrobe(4'h0, 2'h0);
        take = 1'b0;
        apply();
        cyc(3);
        `CHECK("level flag", 1'b1, extIntRequestFlag)
        finishService();
        waitStrobe(4'h0, 2'h0);
        req = '0;
        apply();
        cyc(14);
        `CHECK("flag off", 1'b0, extIntRequestFlag)
    endtask

    task automatic edgePin();
        edgeMode = 1'b1;
        quiet();
        // high then low, each for over one machine cycle
        cyc(14);
        `CHECK("edge idle", 1'b0, extIntRequestFlag)
        @(posedge clk) extIntPin <= 1'b0;
        cyc(14);
        @(posedge clk) extIntPin <= 1'b1;
        cyc(14);
        `CHECK("edge flag", 1'b1, extIntRequestFlag)
        take = 1'b1;
        apply();
        waitStrobe(4'h0, 2'h0);
        cyc(3);
        `CHECK("edge clear", 1'b0, extIntRequestFlag)
        finishService();
        noStrobe();
    endtask

    initial
    begin
        cyc(10);
        rst <= 1'b0;
        cyc(2);
        vectorScan();
        blockCheck();
        rankScan();
        levelPick();
        preempt();
        levelPin();
        edgePin();
        conclude();
    end
endmodule
